// *** valve_train_params.svh ***
// Notes on behaviour
// - Each valve's actuation train has its own independent hold or run mode selection.
// - Selecting hold keeps the valve where it is; no actuation output changes.
// - A hold selection affects only its own train and valve, nothing else.
// - Mode changes only on a switch press; releasing a switch changes nothing.
// - Hold is entered on command, but a running 60 s shut drive finishes first.
// - Each train and valve has its own lamp, lit exactly while hold is in effect.
// - Entering hold freezes actuation, drops status, lights lamp, closes test contacts.
// - Actuation outputs freeze strictly before the test contacts close.
// - Leaving hold opens contacts, then drops lamp and restores status; actuation is released a cycle later.
// - Steam valve logic and feed valve logic live in separate instances.
// - One test contact per train per valve; open normally, closed only in hold.
// - After any shut command outside hold, drive-shut lasts 60 s, then becomes hold-shut.
// - While in hold, no all-shut, shut, trigger or open command alters outputs.
`ifndef VALVE_TRAIN_PARAMS_SVH
`define VALVE_TRAIN_PARAMS_SVH

// Clock rate
`define VT_CLK_HZ 20000000

// Drive-shut duration and its cycle count
`define VT_SHUT_TIME_S 60
`define VT_SHUT_CYCLES (`VT_SHUT_TIME_S * `VT_CLK_HZ)

// Switch debounce time and its cycle count
`define VT_DBNC_TIME_US 1000
`define VT_DBNC_CYCLES (`VT_DBNC_TIME_US * (`VT_CLK_HZ / 1000000))

// Register byte offsets
`define VT_OFS_STATUS 12'h000
`define VT_OFS_DBNC 12'h004

// Status register field positions
`define VT_ST_HOLD_POS 0
`define VT_ST_PEND_POS 8
`define VT_ST_TACT_POS 16

// Reset values
`define VT_DBNC_RST 16'(`VT_DBNC_CYCLES)
`define VT_RDATA_RST 32'h0000_0000

`endif

// *** valve_train_pkg.sv ***
package valve_train_pkg;

  // Hold / run mode sequence, one-hot
  typedef enum logic [4:0] {
    M_RUN    = 5'b00001,
    M_PEND   = 5'b00010,
    M_FREEZE = 5'b00100,
    M_HOLD   = 5'b01000,
    M_OPENC  = 5'b10000
  } mode_state_t;

  // Valve actuation state, one-hot
  typedef enum logic [2:0] {
    SH_OPEN  = 3'b001,
    SH_DRIVE = 3'b010,
    SH_HOLD  = 3'b100
  } shut_state_t;

  // Actuation output bundle of one valve
  typedef struct packed {
    logic drive_shut;
    logic hold_shut;
    logic run_open;
  } act_out_t;

endpackage : valve_train_pkg

// *** mode_switch_filter.sv ***
`timescale 1ns/1ps
module mode_switch_filter #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Raw switch and settings
  input wire logic sw_i,
  input wire logic [CNT_W-1:0] dbnc_len_i,
  // One-cycle press pulse
  output logic press_o
);

  logic sync1_r;
  logic sync2_r;
  logic stable_r;
  logic press_r;
  logic [CNT_W-1:0] cnt_r;

  wire differ_w = (sync2_r != stable_r);
  wire settled_w = differ_w && (cnt_r >= dbnc_len_i);

  // Two-flop synchroniser
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= sw_i;
      sync2_r <= sync1_r;
    end
  end

  // Debounce counter; only a new closed level makes a press
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_r <= 1'b0;
      cnt_r <= '0;
      press_r <= 1'b0;
    end else begin
      cnt_r <= (differ_w && !settled_w) ? cnt_r + 1'b1 : '0;
      if (settled_w) stable_r <= sync2_r;
      press_r <= settled_w && sync2_r; // Release gives no press
    end
  end

  assign press_o = press_r;

endmodule : mode_switch_filter

// *** valve_train_hold_mode_ctrl.sv ***
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "valve_train_params.svh"
module valve_train_hold_mode_ctrl
  import valve_train_pkg::*;
#(
  parameter int NUM_VALVES = 4,
  parameter int DBNC_W = 16,
  parameter int unsigned SHUT_CYCLES = `VT_SHUT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Operator mode switches, one per valve
  input wire logic [NUM_VALVES-1:0] mode_sw_i,
  // Commands from the command logic
  input wire logic all_shut_i,
  input wire logic safety_actuation_trigger_i,
  input wire logic [NUM_VALVES-1:0] shut_i,
  input wire logic [NUM_VALVES-1:0] open_i,
  // Outputs to solenoids, status, lamps and test circuits
  output act_out_t [NUM_VALVES-1:0] act_o,
  output logic [NUM_VALVES-1:0] status_o,
  output logic [NUM_VALVES-1:0] lamp_o,
  output logic [NUM_VALVES-1:0] test_contact_o,
  output logic [NUM_VALVES-1:0] shut_timer_active_o
);

  localparam int CMD_W = 2 * NUM_VALVES + 2;
  localparam logic [30:0] SHUT_LOAD = 31'(SHUT_CYCLES - 1);

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [DBNC_W-1:0] dbnc_len_r;
  logic [NUM_VALVES-1:0] hold_w;
  logic [NUM_VALVES-1:0] pend_w;
  logic [NUM_VALVES-1:0] tact_w;

  // Address phase decode
  wire addr_ph_w = hsel_i && hready_i && htrans_i[1];
  wire hit_status_w = (haddr_i[11:0] == `VT_OFS_STATUS) && (haddr_i[31:12] == 20'h00000);
  wire hit_dbnc_w = (haddr_i[11:0] == `VT_OFS_DBNC) && (haddr_i[31:12] == 20'h00000);
  wire wr_dbnc_w = wr_pend_r && (wr_addr_r == `VT_OFS_DBNC);

  // Read sources; unmapped addresses read zero
  wire [31:0] rd_status_w = (32'(hold_w) << `VT_ST_HOLD_POS)
                          | (32'(pend_w) << `VT_ST_PEND_POS)
                          | (32'(tact_w) << `VT_ST_TACT_POS);
  wire [31:0] rd_dbnc_w = 32'(dbnc_len_r);
  wire [31:0] rd_mux_w = hit_status_w ? rd_status_w
                       : hit_dbnc_w ? rd_dbnc_w : 32'h0000_0000;

  // Capture address phase; zero wait states, always OKAY
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata_r <= `VT_RDATA_RST;
    end else begin
      wr_pend_r <= addr_ph_w && hwrite_i;
      if (addr_ph_w) wr_addr_r <= haddr_i[11:0];
      if (addr_ph_w && !hwrite_i) hrdata_r <= rd_mux_w;
    end
  end

  // Debounce length register, written in the data phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbnc_len_r <= DBNC_W'(`VT_DBNC_RST);
    end else if (wr_dbnc_w) begin
      dbnc_len_r <= hwdata_i[DBNC_W-1:0];
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ---------------------------------------------------------------
  // Command input synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [CMD_W-1:0] cmd_s1_r;
  logic [CMD_W-1:0] cmd_s2_r;
  logic [CMD_W-1:0] cmd_d_r;

  wire [CMD_W-1:0] cmd_raw_w = {open_i, shut_i, safety_actuation_trigger_i, all_shut_i};
  wire [CMD_W-1:0] cmd_rise_w = cmd_s2_r & ~cmd_d_r;

  // Two flops, then a delayed copy for edges
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
      cmd_d_r <= '0;
    end else begin
      cmd_s1_r <= cmd_raw_w;
      cmd_s2_r <= cmd_s1_r;
      cmd_d_r <= cmd_s2_r;
    end
  end

  // Group-wide commands
  wire all_lvl_w = cmd_s2_r[0];
  wire trig_lvl_w = cmd_s2_r[1];
  wire all_rise_w = cmd_rise_w[0];
  wire trig_rise_w = cmd_rise_w[1];

  // ---------------------------------------------------------------
  // Per-valve train; one instance serves one valve group only
  // ---------------------------------------------------------------
  genvar v;
  generate
    for (v = 0; v < NUM_VALVES; v++) begin : g_valve
      mode_state_t mode_r;
      mode_state_t mode_nxt;
      shut_state_t sh_r;
      shut_state_t sh_nxt;
      logic [30:0] timer_r;
      logic [30:0] timer_nxt;
      act_out_t act_r;
      logic status_r;
      logic lamp_r;
      logic contact_r;
      logic tact_r;
      logic press_w;

      // Own debounced switch per valve
      mode_switch_filter #(
        .CNT_W(DBNC_W)
      ) u_filter (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .sw_i(mode_sw_i[v]),
        .dbnc_len_i(dbnc_len_r),
        .press_o(press_w)
      );

      // Per-valve command terms
      wire shut_lvl_w = cmd_s2_r[2 + v];
      wire open_rise_w = cmd_rise_w[2 + NUM_VALVES + v];
      wire shut_go_w = all_rise_w || trig_rise_w || cmd_rise_w[2 + v];
      wire shut_on_w = all_lvl_w || trig_lvl_w || shut_lvl_w;
      // Busy until the drive-shut output itself has dropped, so it is never frozen on
      wire busy_w = (sh_r == SH_DRIVE) || shut_go_w || act_r.drive_shut;

      // Hold entry allowed only with no shut drive running
      wire enter_w = (mode_nxt == M_FREEZE) && (mode_r != M_FREEZE);
      wire frozen_w = (mode_r == M_FREEZE) || (mode_r == M_HOLD) || (mode_r == M_OPENC);
      wire stall_w = frozen_w || enter_w;

      // Mode sequence
      always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
          M_RUN: begin
            if (press_w) mode_nxt = busy_w ? M_PEND : M_FREEZE;
          end
          M_PEND: begin
            if (press_w) mode_nxt = M_RUN;
            else if (!busy_w) mode_nxt = M_FREEZE;
          end
          M_FREEZE: mode_nxt = M_HOLD; // Outputs frozen one cycle first
          M_HOLD: begin
            if (press_w) mode_nxt = M_OPENC;
          end
          M_OPENC: mode_nxt = M_RUN; // Contacts open before release
          default: mode_nxt = M_RUN;
        endcase
      end

      // Shut drive and timer; held still while frozen
      always_comb begin
        sh_nxt = sh_r;
        timer_nxt = timer_r;
        if (!stall_w) begin
          if (shut_go_w) begin
            sh_nxt = SH_DRIVE;
            timer_nxt = SHUT_LOAD;
          end else if (sh_r == SH_DRIVE) begin
            if (timer_r == 31'h0) sh_nxt = SH_HOLD;
            else timer_nxt = timer_r - 31'h1;
          end else if (open_rise_w && !shut_on_w) begin
            sh_nxt = SH_OPEN;
          end
        end
      end

      // Mode and shut state registers
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mode_r <= M_RUN;
          sh_r <= SH_OPEN;
          timer_r <= 31'h0;
        end else begin
          mode_r <= mode_nxt;
          sh_r <= sh_nxt;
          timer_r <= timer_nxt;
        end
      end

      // Actuation latch: frozen at the as-found value
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          act_r <= '{drive_shut: 1'b0, hold_shut: 1'b0, run_open: 1'b1};
        end else if (!stall_w) begin
          act_r.drive_shut <= (sh_r == SH_DRIVE);
          act_r.hold_shut <= (sh_r == SH_HOLD);
          act_r.run_open <= (sh_r == SH_OPEN);
        end
      end

      // Status, lamp and test contact follow the mode sequence
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          status_r <= 1'b1;
          lamp_r <= 1'b0;
          contact_r <= 1'b0;
          tact_r <= 1'b0;
        end else begin
          status_r <= (mode_nxt == M_RUN) || (mode_nxt == M_PEND);
          lamp_r <= (mode_nxt == M_FREEZE) || (mode_nxt == M_HOLD)
                    || (mode_nxt == M_OPENC);
          contact_r <= (mode_nxt == M_HOLD);
          tact_r <= (sh_r == SH_DRIVE); // Same edge as drive_shut
        end
      end

      // Drive ports and status bits
      assign act_o[v] = act_r;
      assign status_o[v] = status_r;
      assign lamp_o[v] = lamp_r;
      assign test_contact_o[v] = contact_r;
      assign shut_timer_active_o[v] = tact_r;
      assign hold_w[v] = lamp_r;
      assign pend_w[v] = (mode_r == M_PEND);
      assign tact_w[v] = tact_r;
    end
  endgenerate

endmodule : valve_train_hold_mode_ctrl

// *** valve_train_hold_mode_ctrl_chk.sv ***
`timescale 1ns/1ps
module valve_train_hold_mode_ctrl_chk
  import valve_train_pkg::*;
#(
  parameter int NUM_VALVES = 4,
  parameter int unsigned SHUT_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watched outputs
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire act_out_t [NUM_VALVES-1:0] act_o,
  input wire logic [NUM_VALVES-1:0] status_o,
  input wire logic [NUM_VALVES-1:0] lamp_o,
  input wire logic [NUM_VALVES-1:0] test_contact_o,
  input wire logic [NUM_VALVES-1:0] shut_timer_active_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  int unsigned drv_cnt_r;
  // Counts drive-shut cycles of valve 0
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i) drv_cnt_r <= 0;
    else drv_cnt_r <= act_o[0].drive_shut ? drv_cnt_r + 1 : 0;
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or errored");
  status_dark_a: assert property ((lamp_o & status_o) == '0)
    else $error("status energized while lamp lit");
  contact_lamp_a: assert property ((test_contact_o & ~lamp_o) == '0)
    else $error("contact closed without lamp");
  enter_order_a: assert property ($rose(lamp_o[0]) |=> $rose(test_contact_o[0]))
    else $error("contact not closed one cycle after freeze");
  exit_order_a: assert property ($fell(test_contact_o[0]) |=> $fell(lamp_o[0]) && $rose(status_o[0]))
    else $error("exit order broken");
  act_frozen_a: assert property (lamp_o[0] && $past(lamp_o[0]) |-> $stable(act_o[0]))
    else $error("actuation moved while held");
  drive_len_a: assert property ($fell(act_o[0].drive_shut) |-> drv_cnt_r == SHUT_CYCLES && act_o[0].hold_shut)
    else $error("drive-shut length wrong");
  timer_drive_a: assert property (shut_timer_active_o[0] |-> act_o[0].drive_shut)
    else $error("timer active outside drive-shut");
endmodule : valve_train_hold_mode_ctrl_chk

// *** op_panel.sv ***
`timescale 1ns/1ps
module op_panel #(
  parameter int NUM_VALVES = 4
) (
  // Clock
  input wire logic clk_sys_i,
  // Switches and command levels
  output logic [NUM_VALVES-1:0] mode_sw_o,
  output logic all_shut_o,
  output logic trig_o,
  output logic [NUM_VALVES-1:0] shut_o,
  output logic [NUM_VALVES-1:0] open_o
);
  // Idle levels at time zero
  initial begin
    mode_sw_o = '0;
    all_shut_o = 1'b0;
    trig_o = 1'b0;
    shut_o = '0;
    open_o = '0;
  end
  // Moves one switch; a release is a plain level change
  task automatic sw_set(input int v, input logic l);
    @(posedge clk_sys_i);
    mode_sw_o[v] <= l;
  endtask : sw_set
  // Pulses a command: 0 shut, 1 open, 2 all-shut, 3 trigger
  task automatic cmd(input int k, input int v);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_sys_i);
      case (k)
        0: shut_o[v] <= i[0];
        1: open_o[v] <= i[0];
        2: all_shut_o <= i[0];
        default: trig_o <= i[0];
      endcase
      repeat (6) @(posedge clk_sys_i);
    end
  endtask : cmd
endmodule : op_panel

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c) begin int k; k = 0; while (!(c) && k < 200) begin \
  @(posedge clk_sys_i); #1; k++; end \
  if (!(c)) begin bad_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1); end end
module tb_top;
  import valve_train_pkg::*;
  localparam int NV = 4;
  localparam int unsigned SC = 50;
  logic clk_sys_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, all_shut_i, trig_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i;
  logic [NV-1:0] mode_sw_i, shut_i, open_i, status_o, lamp_o, test_contact_o, tact_o;
  act_out_t [NV-1:0] act_o;
  act_out_t act0;
  int bad_count = 0;
  int samples_checked = 0;
  valve_train_hold_mode_ctrl #(.NUM_VALVES(NV), .DBNC_W(16), .SHUT_CYCLES(SC))
    valve_train_hold_mode_ctrl_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .mode_sw_i(mode_sw_i),
    .all_shut_i(all_shut_i), .safety_actuation_trigger_i(trig_i), .shut_i(shut_i),
    .open_i(open_i), .act_o(act_o), .status_o(status_o), .lamp_o(lamp_o),
    .test_contact_o(test_contact_o), .shut_timer_active_o(tact_o));
  op_panel #(.NUM_VALVES(NV)) op_panel_i (.clk_sys_i(clk_sys_i), .mode_sw_o(mode_sw_i),
    .all_shut_o(all_shut_i), .trig_o(trig_i), .shut_o(shut_i), .open_o(open_i));
  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Bus idle and reset for two cycles
  initial begin
    {rst_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  end
  // One single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_sys_i);
    {hsel_i, htrans_i, haddr_i, hwrite_i} <= {1'b1, 2'h2, a, w};
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    {hsel_i, htrans_i, hwdata_i} <= {1'b0, 2'h0, d};
    do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask : ahb
  task automatic t_reset;
    `CHK(act_o, {NV{3'b001}})
    `CHK({status_o, lamp_o, test_contact_o}, 12'hf00)
  endtask : t_reset
  task automatic t_bus;
    ahb(1'b1, 32'h4, 32'h0001_0004, rd);
    ahb(1'b1, 32'h0, 32'hffff_ffff, rd);
    ahb(1'b0, 32'h4, 32'h0, rd);
    `CHK(rd, 32'h4)
    ahb(1'b0, 32'h8, 32'h0, rd);
    `CHK(rd, 32'h0)
    ahb(1'b0, 32'h0, 32'h0, rd);
    `CHK(rd, 32'h0)
    `CHK({hreadyout_o, hresp_o}, 2'b10)
  endtask : t_bus
  task automatic t_hold;
    act0 = act_o[0];
    op_panel_i.sw_set(0, 1'b1);
    `WAIT(lamp_o[0])
    `CHK({lamp_o[0], status_o[0], test_contact_o[0]}, 3'b100)
    @(posedge clk_sys_i);
    #1;
    `CHK(test_contact_o[0], 1'b1)
    `CHK({lamp_o[3:1], status_o[3:1], test_contact_o[3:1]}, 9'h038)
    op_panel_i.cmd(0, 0);
    op_panel_i.cmd(1, 0);
    `CHK(act_o[0], act0)
    op_panel_i.sw_set(0, 1'b0);
    repeat (20) @(posedge clk_sys_i);
    #1;
    `CHK(lamp_o[0], 1'b1)
    op_panel_i.sw_set(0, 1'b1);
    `WAIT(!test_contact_o[0])
    `CHK({lamp_o[0], status_o[0]}, 2'b10)
    @(posedge clk_sys_i);
    #1;
    `CHK({lamp_o[0], status_o[0], act_o[0]}, {2'b01, act0})
    op_panel_i.sw_set(0, 1'b0);
    repeat (12) @(posedge clk_sys_i);
  endtask : t_hold
  task automatic t_pend;
    op_panel_i.cmd(0, 0);
    op_panel_i.sw_set(0, 1'b1);
    repeat (12) @(posedge clk_sys_i);
    ahb(1'b0, 32'h0, 32'h0, rd);
    `CHK({rd[16], rd[8], rd[0], lamp_o[0]}, 4'b1100)
    `WAIT(lamp_o[0])
    `CHK(act_o[0], 3'b010)
    op_panel_i.sw_set(0, 1'b0);
    repeat (12) @(posedge clk_sys_i);
    op_panel_i.sw_set(0, 1'b1);
    `WAIT(!lamp_o[0])
    `CHK(status_o[0], 1'b1)
    op_panel_i.sw_set(0, 1'b0);
  endtask : t_pend
  task automatic t_trig;
    op_panel_i.cmd(3, 0);
    `CHK(tact_o, 4'hf)
    op_panel_i.cmd(1, 2);
    `CHK(act_o[2], 3'b100)
    `WAIT(act_o[2].hold_shut)
    op_panel_i.cmd(1, 2);
    `CHK({act_o[2], act_o[1]}, 6'b001010)
    op_panel_i.cmd(2, 0);
    `CHK(act_o[2], 3'b100)
  endtask : t_trig
  // Counts and verdict
  task automatic print_verdict;
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    @(posedge rst_n_i);
    @(posedge clk_sys_i);
    #1;
    t_reset;
    t_bus;
    t_hold;
    t_pend;
    t_trig;
    print_verdict;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    print_verdict;
  end
endmodule : tb_top
bind valve_train_hold_mode_ctrl valve_train_hold_mode_ctrl_chk #(.NUM_VALVES(NUM_VALVES),
  .SHUT_CYCLES(SHUT_CYCLES)) chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .act_o(act_o), .status_o(status_o),
  .lamp_o(lamp_o), .test_contact_o(test_contact_o),
  .shut_timer_active_o(shut_timer_active_o));
